/* File: bench/spirp_host.sv */
// Host model driving the serial port as master
`default_nettype none
// ==========
// Host
// ==========
module spirp_host (
  input wire logic clk_sys_i,
  input wire logic sdo_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] wd [8];
  logic [15:0] rd [8];
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wt
  task automatic xfer(input logic [15:0] cmd, input int nb, input logic idle, input logic cs);
    logic [15:0] w;
    sclk_o <= idle;
    wt(4);
    cs_n_o <= !cs;
    wt(4);
    for (int i = 0; i < nb; i++) begin
      w = (i < 16) ? cmd : wd[i/16-1];
      sclk_o <= 1'b0;
      sdi_o <= w[15 - i%16];
      wt(4);
      sclk_o <= 1'b1;
      wt(4);
      if (i >= 16) rd[i/16-1][15 - i%16] = sdo_i;
    end
    sdi_o <= !sdi_o;
    cs_n_o <= 1'b1;
    sclk_o <= idle;
    wt(8);
  endtask : xfer
endmodule : spirp_host
`default_nettype wire

/* File: bench/spirp_monitor.sv */
// Port checker for the serial register port
`default_nettype none
// ==========
// Checker
// ==========
module spirp_monitor
  import spirp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe_o,
  input wire logic reg_wr_o,
  input wire logic reg_rd_o,
  input wire logic [ADDR_W-1:0] reg_addr_o,
  input wire logic [WORD_W-1:0] reg_wdata_o,
  input wire logic [WORD_W-1:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wr_gap_a: assert property (reg_wr_o |=> (!reg_wr_o) [*8])
    else $error("write strobes too close");
  rd_gap_a: assert property (reg_rd_o |=> (!reg_rd_o) [*8])
    else $error("read strobes too close");
  dir_excl_a: assert property (!(reg_wr_o && reg_rd_o))
    else $error("read and write together");
  cs_gate_a: assert property (spi_cs_n_i [*5] |-> !(reg_wr_o || reg_rd_o || spi_sdo_oe_o))
    else $error("activity while deselected");
  sdo_fall_a: assert property (spi_sdo_oe_o && $changed(spi_sdo_o)
    |-> !spi_sclk_i && !$past(spi_sclk_i, 2)) else $error("sdo moved off falling edge");
  str_rise_a: assert property ((reg_wr_o || reg_rd_o)
    |-> spi_sclk_i && $past(spi_sclk_i, 2)) else $error("strobe off rising edge");
  rd_oe_a: assert property (reg_rd_o |-> ##[1:3] spi_sdo_oe_o)
    else $error("read without sdo drive");
  wr_hold_a: assert property (reg_wr_o |=> $stable(reg_wdata_o) && $stable(reg_addr_o))
    else $error("write data not held");
  cover property (reg_wr_o);
  cover property (reg_rd_o ##[1:300] reg_rd_o);
  cover property (spi_sdo_oe_o && spi_sdo_o);
endmodule : spirp_monitor
`default_nettype wire

/* File: bench/test_spirp_port.sv */
// Self-checking bench for the serial register port
`default_nettype none
// ==========
// Bench
// ==========
module test_spirp_port
  import spirp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] cmd; int nb; logic idle; logic cs;} spirp_row_t;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic spi_cs_n_i, spi_sclk_i, spi_sdi_i, spi_sdo_o, spi_sdo_oe_o, reg_wr_o, reg_rd_o;
  logic [ADDR_W-1:0] reg_addr_o;
  logic [WORD_W-1:0] reg_wdata_o;
  logic [WORD_W-1:0] reg_rdata_i = 16'h0000;
  logic [WORD_W-1:0] rf [1024];
  wire sdo_w = spi_sdo_oe_o ? spi_sdo_o : 1'b1;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int wcnt = 0;
  spirp_row_t rows [8] = '{'{16'he7fd, 80, 1'b1, 1'b1}, '{16'he405, 48, 1'b0, 1'b1},
    '{16'hec05, 32, 1'b1, 1'b1}, '{16'he005, 32, 1'b0, 1'b1}, '{16'he3fe, 64, 1'b1, 1'b1},
    '{16'hf005, 32, 1'b0, 1'b1}, '{16'he010, 40, 1'b1, 1'b1}, '{16'he020, 32, 1'b0, 1'b0}};
  always #10 clk_sys_i = ~clk_sys_i;
  spirp_port DUT (.clk_sys_i, .rst_n_i, .spi_cs_n_i, .spi_sclk_i, .spi_sdi_i, .spi_sdo_o,
    .spi_sdo_oe_o, .reg_wr_o, .reg_rd_o, .reg_addr_o, .reg_wdata_o, .reg_rdata_i);
  spirp_host pm (.clk_sys_i, .sdo_i(sdo_w), .cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i),
    .sdi_o(spi_sdi_i));
  // Register file behind the strobe port
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (reg_wr_o === 1'b1) begin
      rf[reg_addr_o] <= reg_wdata_o;
      wcnt <= wcnt + 1;
    end
    if (reg_rd_o === 1'b1) reg_rdata_i <= rf[reg_addr_o];
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic run(input spirp_row_t r, input int ri);
    logic ok;
    logic [15:0] e;
    int a, nw, nx, w0;
    ok = r.cs && (r.cmd[15:11] === ENABLE_PATTERN);
    a = r.cmd[9:0];
    nw = (r.nb - 16) / 16;
    for (int k = 0; k < 8; k++) pm.wd[k] = 16'h5000 + 16'(ri * 16 + k);
    w0 = wcnt;
    pm.xfer(r.cmd, r.nb, r.idle, r.cs);
    nx = (ok && r.cmd[10] === 1'b0) ? ((nw < 1024 - a) ? nw : 1024 - a) : 0;
    chk(16'(wcnt - w0), 16'(nx));
    for (int k = 0; k < nx; k++) chk(rf[a + k], pm.wd[k]);
    for (int k = 0; k < nw; k++) begin
      e = (a + k > 1023) ? 16'h9fff : 16'h9c00 ^ 16'(a + k);
      if (!(ok && r.cmd[10] === DIR_READ)) e = 16'hffff;
      chk(pm.rd[k], e);
    end
  endtask : run
  initial begin
    for (int i = 0; i < 1024; i++) rf[i] = 16'h9c00 ^ 16'(i);
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    foreach (rows[i]) run(rows[i], i);
    // Reset in mid-run, then a write must still land
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk({3'h0, reg_wr_o, reg_rd_o, spi_sdo_oe_o, reg_addr_o}, 16'h0000);
    chk(reg_wdata_o, 16'h0000);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    run(rows[3], 8);
    close_out();
  end
endmodule : test_spirp_port
bind spirp_port spirp_monitor u_mon (.clk_sys_i, .rst_n_i, .spi_cs_n_i, .spi_sclk_i,
  .spi_sdi_i, .spi_sdo_o, .spi_sdo_oe_o, .reg_wr_o, .reg_rd_o, .reg_addr_o, .reg_wdata_o,
  .reg_rdata_i);
`default_nettype wire

/* File: hw/spirp_port.sv */
// Serial register port: constants package and the four-wire slave engine
`default_nettype none

// ============================================================
// Package
// ============================================================
package spirp_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned ENABLE_W = 5;
  // Command word fields
  localparam int unsigned ENABLE_MSB = 15;
  localparam int unsigned ENABLE_LSB = 11;
  localparam int unsigned DIR_BIT = 10;
  localparam int unsigned ADDR_MSB = 9;
  localparam int unsigned ADDR_LSB = 0;
  localparam logic [ENABLE_W-1:0] ENABLE_PATTERN = 5'h1c;
  localparam logic DIR_READ = 1'h1;
  // Pointer limits and counters
  localparam logic [ADDR_W-1:0] ADDR_MAX = 10'h3ff;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 10'h001;
  localparam logic [CNT_W-1:0] CNT_LAST = 4'hf;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
  // Reset levels of synchronised pins
  localparam logic CS_IDLE = 1'h1;
  localparam logic PIN_LOW = 1'h0;

  typedef enum logic [1:0] {
    SPIRP_CMD,
    SPIRP_WRITE,
    SPIRP_READ,
    SPIRP_IGNORE
  } spirp_state_t;
endpackage : spirp_pkg

// ============================================================
// Functional notes
// ============================================================
// Functional notes
// - Each output bit is driven on the falling serial clock edge.
// - Input bits are sampled on the rising serial clock edge.
// - Only enable pattern 11100 in bits 15..11 starts a valid transaction.
// - Command bit 10 high means read, low means write.
// - Command bits 9..0 give the first register address.
// - Write data words follow the command; first goes to the addressed register.
// - Each further written word goes to the next register address.
// - Writes continue until chip select rises or pointer hits maximum; no wrap.
// - Past the maximum address further write data is discarded.
// - Serial clock may idle high or low between transactions.
// - First read bit appears on first falling edge after command.
// - Read data keeps shifting until chip select rises.
// - At maximum address every further read word repeats the last register.
// - Clock and data are honoured only while chip select is low.
module spirp_port
  import spirp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [ADDR_W-1:0] reg_addr_o,
  output logic [WORD_W-1:0] reg_wdata_o,
  input wire logic [WORD_W-1:0] reg_rdata_i
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;

  spirp_sync #(.RST_VAL(CS_IDLE)) u_sync_cs (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .d_i(spi_cs_n_i),
    .q_o(cs_n_s)
  );

  spirp_sync #(.RST_VAL(PIN_LOW)) u_sync_sclk (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .d_i(spi_sclk_i),
    .q_o(sclk_s)
  );

  spirp_sync #(.RST_VAL(PIN_LOW)) u_sync_sdi (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .d_i(spi_sdi_i),
    .q_o(sdi_s)
  );

  // ==========================================================
  // Edge detection
  // ==========================================================
  logic sclk_prev;
  wire logic selected = !cs_n_s;
  // Edges only count while selected, so either idle level is harmless
  wire logic sclk_rise = selected && sclk_s && !sclk_prev;
  wire logic sclk_fall = selected && !sclk_s && sclk_prev;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= PIN_LOW;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  // ==========================================================
  // Receive shifter and word decode
  // ==========================================================
  spirp_state_t state;
  spirp_state_t next_state;
  logic [WORD_W-1:0] rx_shift;
  logic [CNT_W-1:0] bit_cnt;
  logic [ADDR_W-1:0] addr_ptr;
  logic at_max;
  logic [WORD_W-1:0] tx_shift;
  logic load_pend;

  wire logic [WORD_W-1:0] rx_word = {rx_shift[WORD_W-2:0], sdi_s};
  wire logic word_done = sclk_rise && (bit_cnt == CNT_LAST);
  wire logic [ENABLE_W-1:0] cmd_enable = rx_word[ENABLE_MSB:ENABLE_LSB];
  wire logic cmd_ok = (cmd_enable == ENABLE_PATTERN);
  wire logic cmd_read = (rx_word[DIR_BIT] == DIR_READ);
  wire logic [ADDR_W-1:0] cmd_addr = rx_word[ADDR_MSB:ADDR_LSB];
  wire logic in_cmd = (state == SPIRP_CMD);
  wire logic in_write = (state == SPIRP_WRITE);
  wire logic in_read = (state == SPIRP_READ);
  wire logic ptr_is_max = (addr_ptr == ADDR_MAX);
  wire logic [ADDR_W-1:0] addr_inc = addr_ptr + ADDR_ONE;

  // Register strobes
  wire logic cmd_rd_go = word_done && in_cmd && cmd_ok && cmd_read;
  wire logic burst_rd_go = word_done && in_read;
  wire logic wr_go = word_done && in_write && !at_max;
  wire logic cmd_load = word_done && in_cmd;
  // At the top of the map the pointer holds, so reads repeat the last register
  wire logic [ADDR_W-1:0] burst_rd_addr = ptr_is_max ? addr_ptr : addr_inc;

  always_comb begin
    next_state = state;
    if (word_done && in_cmd) begin
      if (!cmd_ok) begin
        next_state = SPIRP_IGNORE;
      end else if (cmd_read) begin
        next_state = SPIRP_READ;
      end else begin
        next_state = SPIRP_WRITE;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= SPIRP_CMD;
    end else if (cs_n_s) begin
      // Deselect ends any transaction and rearms for a command word
      state <= SPIRP_CMD;
    end else if (sclk_rise) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= CNT_ZERO;
      rx_shift <= WORD_ZERO;
    end else if (cs_n_s) begin
      bit_cnt <= CNT_ZERO;
      rx_shift <= WORD_ZERO;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + CNT_ONE;
      rx_shift <= rx_word;
    end
  end

  // ==========================================================
  // Address pointer
  // ==========================================================
  // Top register written: later write words are dropped
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      at_max <= 1'b0;
    end else if (cs_n_s || cmd_load) begin
      at_max <= 1'b0;
    end else if (wr_go && ptr_is_max) begin
      at_max <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_ptr <= ADDR_ZERO;
    end else if (cmd_load) begin
      addr_ptr <= cmd_addr;
    end else if (wr_go && !ptr_is_max) begin
      // Pointer stops at the top and never wraps
      addr_ptr <= addr_inc;
    end else if (burst_rd_go) begin
      addr_ptr <= burst_rd_addr;
    end
  end

  // ==========================================================
  // Register access strobes
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_o <= 1'b0;
      reg_rd_o <= 1'b0;
      reg_addr_o <= ADDR_ZERO;
      reg_wdata_o <= WORD_ZERO;
    end else begin
      reg_wr_o <= wr_go;
      reg_rd_o <= cmd_rd_go || burst_rd_go;
      if (wr_go) begin
        reg_addr_o <= addr_ptr;
        reg_wdata_o <= rx_word;
      end else if (cmd_rd_go) begin
        reg_addr_o <= cmd_addr;
      end else if (burst_rd_go) begin
        reg_addr_o <= burst_rd_addr;
      end
    end
  end

  // ==========================================================
  // Transmit shifter
  // ==========================================================
  // Read data returns the cycle after the read strobe
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      load_pend <= 1'b0;
    end else begin
      load_pend <= reg_rd_o;
    end
  end

  // Load lands before the next fall while sclk half period is at least three clocks
  wire logic tx_step = sclk_fall && in_read && !load_pend;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift <= WORD_ZERO;
    end else if (cs_n_s) begin
      tx_shift <= WORD_ZERO;
    end else if (load_pend) begin
      tx_shift <= reg_rdata_i;
    end else if (tx_step) begin
      tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      spi_sdo_o <= 1'b0;
    end else if (cs_n_s) begin
      spi_sdo_o <= 1'b0;
    end else if (tx_step) begin
      spi_sdo_o <= tx_shift[WORD_W-1];
    end
  end

  // Output driven only during a valid read
  assign spi_sdo_oe_o = selected && in_read;

endmodule : spirp_port

`default_nettype wire

/* File: hw/spirp_sync.sv */
// Two-flop synchroniser for one pin from outside the system clock domain
`default_nettype none

// ============================================================
// Synchroniser
// ============================================================
module spirp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);

  logic meta;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : spirp_sync

`default_nettype wire
